// ===== src/tlw_params.svh
// Offsets, field positions and reset values of the table write controller
`ifndef TLW_PARAMS_SVH
`define TLW_PARAMS_SVH

`define TLW_OFS_CTRL        8'h00
`define TLW_OFS_LATCH       8'h04
`define TLW_OFS_POINTER     8'h08
`define TLW_OFS_OP          8'h0c

`define TLW_CTRL_LWE_BIT    0
`define TLW_CTRL_PRIO_BIT   1
`define TLW_CTRL_PIN_BIT    2
`define TLW_CTRL_BUSY_BIT   3
`define TLW_CTRL_LONG_BIT   4
`define TLW_CTRL_STOP_BIT   5

`define TLW_OP_WRITE_BIT    2
`define TLW_OP_MODE_MSB     1
`define TLW_OP_MODE_LSB     0

`define TLW_RST_LATCH       8'h00
`define TLW_RST_POINTER     22'h000000
`define TLW_RST_LWE         1'b0
`define TLW_RST_PRIO        1'b0

`define TLW_IRQ_SOURCES     8

`endif

// ===== src/tlw_pkg.sv
// Types shared by the table write controller modules
package tlw_pkg;

	typedef enum logic [1:0] {
		TLW_IDLE    = 2'b00,
		TLW_READ    = 2'b01,
		TLW_PROGRAM = 2'b10
	} tlw_state_t;

	typedef enum logic [1:0] {
		TLW_PTR_KEEP     = 2'b00,
		TLW_PTR_POST_INC = 2'b01,
		TLW_PTR_POST_DEC = 2'b10,
		TLW_PTR_PRE_INC  = 2'b11
	} tlw_ptr_mode_t;

	typedef struct packed {
		logic          isWrite;
		tlw_ptr_mode_t mode;
	} tlw_op_t;

	typedef struct packed {
		logic terminate;
		logic vecHigh;
		logic vecLow;
	} tlw_wake_t;

	typedef struct packed {
		logic [21:0] access;
		logic [21:0] updated;
	} tlw_ptr_pair_t;

endpackage

// ===== src/tlw_pointer_unit.sv
// Table pointer access address and update for the four pointer modes
`timescale 1ns/1ps
module tlw_pointer_unit (
	input  wire logic [21:0]           pointer,
	input  wire tlw_pkg::tlw_ptr_mode_t mode,
	output tlw_pkg::tlw_ptr_pair_t      result
);

	// Top bit selects configuration space and never takes a carry
	function automatic logic [21:0] tlw_step(input logic [21:0] p, input logic [20:0] d);
		return {p[21], 21'(p[20:0] + d)};
	endfunction

	always_comb begin
		unique case (mode)
			tlw_pkg::TLW_PTR_KEEP: begin
				result.access  = pointer;
				result.updated = pointer;
			end
			tlw_pkg::TLW_PTR_POST_INC: begin
				result.access  = pointer;
				result.updated = tlw_step(pointer, 21'h000001);
			end
			tlw_pkg::TLW_PTR_POST_DEC: begin
				result.access  = pointer;
				result.updated = tlw_step(pointer, 21'h1fffff);
			end
			tlw_pkg::TLW_PTR_PRE_INC: begin
				result.access  = tlw_step(pointer, 21'h000001);
				result.updated = tlw_step(pointer, 21'h000001);
			end
		endcase
	end

endmodule // tlw_pointer_unit

// ===== src/tlw_wake_logic.sv
// Decides whether and how an interrupt ends a long write
`timescale 1ns/1ps
`include "tlw_params.svh"
module tlw_wake_logic (
	input  wire logic [`TLW_IRQ_SOURCES-1:0] irqFlag,
	input  wire logic [`TLW_IRQ_SOURCES-1:0] irqEnable,
	input  wire logic [`TLW_IRQ_SOURCES-1:0] irqPriority,
	input  wire logic                        priorityEnable,
	input  wire logic                        globalHighEnable,
	input  wire logic                        peripheralLowEnable,
	output tlw_pkg::tlw_wake_t               wake
);

	logic [`TLW_IRQ_SOURCES-1:0] hit;
	logic                        anyHigh;
	logic                        anyLow;

	// Disabled sources never count, whatever their flag shows
	assign hit     = irqFlag & irqEnable;
	assign anyHigh = |(hit & irqPriority);
	assign anyLow  = |(hit & ~irqPriority);

	always_comb begin
		wake.terminate = |hit;
		if (priorityEnable) begin
			wake.vecHigh = anyHigh & globalHighEnable;
			wake.vecLow  = anyLow & peripheralLowEnable & ~wake.vecHigh;
		end else begin
			// Compatibility mode: priority bits ignored, one vector
			wake.vecHigh = (|hit) & globalHighEnable;
			wake.vecLow  = 1'b0;
		end
	end

endmodule // tlw_wake_logic

// ===== src/tlw_table_write_ctrl.sv
// Table read/write controller with long write programming of a two-byte block
`timescale 1ns/1ps
`include "tlw_params.svh"
module tlw_table_write_ctrl (
	input  wire logic                        clock,
	input  wire logic                        arst_n,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [7:0]                  paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire logic                        programPinAtVpp,
	input  wire logic [`TLW_IRQ_SOURCES-1:0] irqFlag,
	input  wire logic [`TLW_IRQ_SOURCES-1:0] irqEnable,
	input  wire logic [`TLW_IRQ_SOURCES-1:0] irqPriority,
	input  wire logic                        globalHighEnable,
	input  wire logic                        peripheralLowEnable,
	input  wire logic [7:0]                  memRdByte,
	output logic                             memRdEn,
	output logic      [21:0]                 memRdAddr,
	output logic                             memProgram,
	output logic      [20:0]                 memWordAddr,
	output logic                             memConfigSpace,
	output logic      [15:0]                 memWrData,
	output logic                             coreHalt,
	output logic                             coreSleep,
	output logic                             resumeNext,
	output logic                             vectorHigh,
	output logic                             vectorLow
);

	// Program pin synchroniser; only pinSync is read by logic
	logic                   pinMeta;
	logic                   pinSync;

	tlw_pkg::tlw_state_t    state_reg;
	tlw_pkg::tlw_state_t    state_next;
	logic                   lwe_reg;
	logic                   lwe_next;
	logic                   prioEn_reg;
	logic                   prioEn_next;
	logic [7:0]             latch_reg;
	logic [7:0]             latch_next;
	logic [7:0]             hold_reg;
	logic [7:0]             hold_next;
	logic [21:0]            pointer_reg;
	logic [21:0]            pointer_next;
	tlw_pkg::tlw_op_t       op_reg;
	tlw_pkg::tlw_op_t       op_next;
	logic                   pending_reg;
	logic                   pending_next;
	logic                   lastLong_reg;
	logic                   lastLong_next;
	logic                   lastStop_reg;
	logic                   lastStop_next;
	logic [31:0]            prdata_reg;
	logic [31:0]            prdata_next;
	logic                   pready_reg;
	logic                   pready_next;
	logic                   pslverr_reg;
	logic                   pslverr_next;
	logic                   rdEn_reg;
	logic                   rdEn_next;
	logic [21:0]            rdAddr_reg;
	logic [21:0]            rdAddr_next;
	logic                   program_reg;
	logic                   program_next;
	logic [20:0]            wordAddr_reg;
	logic [20:0]            wordAddr_next;
	logic                   cfgSpace_reg;
	logic                   cfgSpace_next;
	logic [15:0]            wrData_reg;
	logic [15:0]            wrData_next;
	logic                   halt_reg;
	logic                   halt_next;
	logic                   resume_reg;
	logic                   resume_next;
	logic                   vecHigh_reg;
	logic                   vecHigh_next;
	logic                   vecLow_reg;
	logic                   vecLow_next;

	tlw_pkg::tlw_ptr_pair_t ptrPair;
	tlw_pkg::tlw_wake_t     wake;
	logic                   busy;
	logic                   apbSetupDone;
	logic                   apbCommit;
	logic                   mapped;
	logic [31:0]            readMux;

	tlw_pointer_unit u_pointer (
		.pointer (pointer_reg),
		.mode    (op_reg.mode),
		.result  (ptrPair)
	);

	tlw_wake_logic u_wake (
		.irqFlag             (irqFlag),
		.irqEnable           (irqEnable),
		.irqPriority         (irqPriority),
		.priorityEnable      (prioEn_reg),
		.globalHighEnable    (globalHighEnable),
		.peripheralLowEnable (peripheralLowEnable),
		.wake                (wake)
	);

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			pinMeta <= 1'b0;
			pinSync <= 1'b0;
		end else begin
			pinMeta <= programPinAtVpp;
			pinSync <= pinMeta;
		end
	end

	assign busy         = (state_reg != tlw_pkg::TLW_IDLE) | pending_reg;
	assign apbSetupDone = psel & penable & ~pready_reg;
	assign apbCommit    = psel & penable & pready_reg & pwrite & ~pslverr_reg;
	assign mapped       = (paddr == `TLW_OFS_CTRL) | (paddr == `TLW_OFS_LATCH) |
	                      (paddr == `TLW_OFS_POINTER) | (paddr == `TLW_OFS_OP);

	// The holding byte is deliberately absent from this mux
	always_comb begin
		readMux = 32'h00000000;
		unique case (paddr)
			`TLW_OFS_CTRL: begin
				readMux[`TLW_CTRL_LWE_BIT]  = lwe_reg;
				readMux[`TLW_CTRL_PRIO_BIT] = prioEn_reg;
				readMux[`TLW_CTRL_PIN_BIT]  = pinSync;
				readMux[`TLW_CTRL_BUSY_BIT] = busy;
				readMux[`TLW_CTRL_LONG_BIT] = lastLong_reg;
				readMux[`TLW_CTRL_STOP_BIT] = lastStop_reg;
			end
			`TLW_OFS_LATCH:   readMux[7:0]  = latch_reg;
			`TLW_OFS_POINTER: readMux[21:0] = pointer_reg;
			`TLW_OFS_OP:      readMux[2:0]  = op_reg;
			default:          readMux       = 32'h00000000;
		endcase
	end

	always_comb begin
		state_next    = state_reg;
		lwe_next      = lwe_reg;
		prioEn_next   = prioEn_reg;
		latch_next    = latch_reg;
		hold_next     = hold_reg;
		pointer_next  = pointer_reg;
		op_next       = op_reg;
		pending_next  = pending_reg;
		lastLong_next = lastLong_reg;
		lastStop_next = lastStop_reg;
		prdata_next   = prdata_reg;
		pready_next   = 1'b0;
		pslverr_next  = 1'b0;
		rdEn_next     = rdEn_reg;
		rdAddr_next   = rdAddr_reg;
		program_next  = program_reg;
		wordAddr_next = wordAddr_reg;
		cfgSpace_next = cfgSpace_reg;
		wrData_next   = wrData_reg;
		halt_next     = halt_reg;
		resume_next   = 1'b0;
		vecHigh_next  = 1'b0;
		vecLow_next   = 1'b0;

		// One wait cycle: data and error are prepared before pready rises
		if (apbSetupDone) begin
			pready_next  = 1'b1;
			prdata_next  = pwrite ? 32'h00000000 : readMux;
			pslverr_next = ~mapped | (pwrite & (paddr == `TLW_OFS_OP) & busy);
		end

		if (apbCommit) begin
			unique case (paddr)
				`TLW_OFS_CTRL: begin
					// Set-only: a written zero cannot clear it
					lwe_next    = lwe_reg | pwdata[`TLW_CTRL_LWE_BIT];
					prioEn_next = pwdata[`TLW_CTRL_PRIO_BIT];
				end
				`TLW_OFS_LATCH:   latch_next   = pwdata[7:0];
				`TLW_OFS_POINTER: pointer_next = pwdata[21:0];
				`TLW_OFS_OP: begin
					op_next.isWrite = pwdata[`TLW_OP_WRITE_BIT];
					op_next.mode    = tlw_pkg::tlw_ptr_mode_t'(
					                  pwdata[`TLW_OP_MODE_MSB:`TLW_OP_MODE_LSB]);
					pending_next    = 1'b1;
				end
				default: begin
				end
			endcase
		end

		unique case (state_reg)
			tlw_pkg::TLW_IDLE: begin
				if (pending_reg) begin
					pending_next = 1'b0;
					pointer_next = ptrPair.updated;
					if (!op_reg.isWrite) begin
						rdAddr_next = ptrPair.access;
						rdEn_next   = 1'b1;
						state_next  = tlw_pkg::TLW_READ;
					end else if (!ptrPair.access[0]) begin
						// Even byte: latch only, nothing reaches the array
						hold_next     = latch_reg;
						lastLong_next = 1'b0;
					end else if (lwe_reg & pinSync) begin
						// Odd byte with voltage and enable: program the block
						wordAddr_next = ptrPair.access[21:1];
						cfgSpace_next = ptrPair.access[21];
						wrData_next   = {latch_reg, hold_reg};
						program_next  = 1'b1;
						halt_next     = 1'b1;
						lastLong_next = 1'b1;
						lastStop_next = 1'b0;
						state_next    = tlw_pkg::TLW_PROGRAM;
					end else begin
						// Short write: array untouched, holding byte kept
						lastLong_next = 1'b0;
					end
				end
			end
			tlw_pkg::TLW_READ: begin
				latch_next = memRdByte;
				rdEn_next  = 1'b0;
				state_next = tlw_pkg::TLW_IDLE;
			end
			tlw_pkg::TLW_PROGRAM: begin
				// No minimum time is enforced here; the wake source sets it
				if (wake.terminate) begin
					program_next  = 1'b0;
					halt_next     = 1'b0;
					lastStop_next = 1'b1;
					vecHigh_next  = wake.vecHigh;
					vecLow_next   = wake.vecLow;
					resume_next   = ~wake.vecHigh & ~wake.vecLow;
					state_next    = tlw_pkg::TLW_IDLE;
				end
			end
			default: begin
				program_next = 1'b0;
				halt_next    = 1'b0;
				rdEn_next    = 1'b0;
				state_next   = tlw_pkg::TLW_IDLE;
			end
		endcase
	end

	// Interrupt flags are inputs only; ending a write never clears them
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			// Power-on and master reset both arrive here and end a long write
			state_reg    <= tlw_pkg::TLW_IDLE;
			lwe_reg      <= `TLW_RST_LWE;
			prioEn_reg   <= `TLW_RST_PRIO;
			latch_reg    <= `TLW_RST_LATCH;
			hold_reg     <= 8'h00;
			pointer_reg  <= `TLW_RST_POINTER;
			op_reg       <= 3'h0;
			pending_reg  <= 1'b0;
			lastLong_reg <= 1'b0;
			lastStop_reg <= 1'b0;
			prdata_reg   <= 32'h00000000;
			pready_reg   <= 1'b0;
			pslverr_reg  <= 1'b0;
			rdEn_reg     <= 1'b0;
			rdAddr_reg   <= 22'h000000;
			program_reg  <= 1'b0;
			wordAddr_reg <= 21'h000000;
			cfgSpace_reg <= 1'b0;
			wrData_reg   <= 16'h0000;
			halt_reg     <= 1'b0;
			resume_reg   <= 1'b0;
			vecHigh_reg  <= 1'b0;
			vecLow_reg   <= 1'b0;
		end else begin
			state_reg    <= state_next;
			lwe_reg      <= lwe_next;
			prioEn_reg   <= prioEn_next;
			latch_reg    <= latch_next;
			hold_reg     <= hold_next;
			pointer_reg  <= pointer_next;
			op_reg       <= op_next;
			pending_reg  <= pending_next;
			lastLong_reg <= lastLong_next;
			lastStop_reg <= lastStop_next;
			prdata_reg   <= prdata_next;
			pready_reg   <= pready_next;
			pslverr_reg  <= pslverr_next;
			rdEn_reg     <= rdEn_next;
			rdAddr_reg   <= rdAddr_next;
			program_reg  <= program_next;
			wordAddr_reg <= wordAddr_next;
			cfgSpace_reg <= cfgSpace_next;
			wrData_reg   <= wrData_next;
			halt_reg     <= halt_next;
			resume_reg   <= resume_next;
			vecHigh_reg  <= vecHigh_next;
			vecLow_reg   <= vecLow_next;
		end
	end

	assign prdata         = prdata_reg;
	assign pready         = pready_reg;
	assign pslverr        = pslverr_reg;
	assign memRdEn        = rdEn_reg;
	assign memRdAddr      = rdAddr_reg;
	assign memProgram     = program_reg;
	assign memWordAddr    = wordAddr_reg;
	assign memConfigSpace = cfgSpace_reg;
	assign memWrData      = wrData_reg;
	assign coreHalt       = halt_reg;
	assign coreSleep      = halt_reg;
	assign resumeNext     = resume_reg;
	assign vectorHigh     = vecHigh_reg;
	assign vectorLow      = vecLow_reg;

endmodule // tlw_table_write_ctrl

// ===== tb/tlw_sva.sv
// Port assertions for the table write controller
`timescale 1ns/1ps
`include "tlw_params.svh"
module tlw_checker (
	input wire logic                        clock,
	input wire logic                        arst_n,
	input wire logic                        psel,
	input wire logic                        penable,
	input wire logic                        pready,
	input wire logic                        pslverr,
	input wire logic                        programPinAtVpp,
	input wire logic [`TLW_IRQ_SOURCES-1:0] irqFlag,
	input wire logic [`TLW_IRQ_SOURCES-1:0] irqEnable,
	input wire logic                        memRdEn,
	input wire logic                        memProgram,
	input wire logic [20:0]                 memWordAddr,
	input wire logic [15:0]                 memWrData,
	input wire logic                        coreHalt,
	input wire logic                        coreSleep,
	input wire logic                        resumeNext,
	input wire logic                        vectorHigh,
	input wire logic                        vectorLow
);
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	wire logic wakeReq = |(irqFlag & irqEnable);
	sequence accessStart;
		$rose(psel && penable);
	endsequence
	sequence endPulse;
		!memProgram && $onehot({resumeNext, vectorHigh, vectorLow});
	endsequence
	bus_wait_a: assert property (accessStart |-> !pready ##1 pready)
		else $error("pready not in second access cycle");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	halt_sleep_a: assert property (coreHalt == memProgram && coreSleep == memProgram)
		else $error("halt or sleep differs from programming");
	prog_pin_a: assert property ($rose(memProgram) |-> programPinAtVpp)
		else $error("programming without programming voltage");
	wake_ends_a: assert property (memProgram && wakeReq |=> endPulse)
		else $error("enabled flag did not end programming");
	no_wake_holds_a: assert property (memProgram && !wakeReq |=> memProgram)
		else $error("programming ended without enabled flag");
	pulse_cause_a: assert property (resumeNext || vectorHigh || vectorLow |-> $fell(memProgram))
		else $error("end pulse without end of programming");
	data_hold_a: assert property (memProgram && $past(memProgram)
		|-> $stable(memWrData) && $stable(memWordAddr))
		else $error("word or data moved while programming");
	read_pulse_a: assert property (memRdEn |=> !memRdEn)
		else $error("read enable longer than one cycle");
endmodule // tlw_checker

bind tlw_table_write_ctrl tlw_checker tlw_checker_i (.clock(clock), .arst_n(arst_n),
	.psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
	.programPinAtVpp(programPinAtVpp), .irqFlag(irqFlag), .irqEnable(irqEnable),
	.memRdEn(memRdEn), .memProgram(memProgram), .memWordAddr(memWordAddr),
	.memWrData(memWrData), .coreHalt(coreHalt), .coreSleep(coreSleep),
	.resumeNext(resumeNext), .vectorHigh(vectorHigh), .vectorLow(vectorLow));

// ===== tb/tlw_mem_model.sv
// Behavioural program memory array behind the controller
`timescale 1ns/1ps
module tlw_mem_model (
	input  wire logic        clock,
	input  wire logic        memRdEn,
	input  wire logic [21:0] memRdAddr,
	input  wire logic        memProgram,
	input  wire logic [20:0] memWordAddr,
	input  wire logic [15:0] memWrData,
	output logic      [7:0]  memRdByte
);
	// Only 256 bytes kept; higher addresses alias onto them
	logic [7:0] mem [256];
	logic [7:0] lastByte;
	logic       progPrev;
	initial begin
		foreach (mem[i]) mem[i] = 8'hff;
		lastByte = 8'h00;
		progPrev = 1'h0;
	end
	// Off a read the bus shows the inverse of the last byte, never a stale copy
	assign memRdByte = memRdEn ? mem[memRdAddr[7:0]] : ~lastByte;
	always @(posedge clock) begin
		progPrev <= memProgram;
		if (memRdEn) lastByte <= mem[memRdAddr[7:0]];
		if (memProgram && !progPrev) begin
			mem[{memWordAddr[6:0], 1'h0}] <= memWrData[7:0];
			mem[{memWordAddr[6:0], 1'h1}] <= memWrData[15:8];
		end
	end
endmodule // tlw_mem_model

// ===== tb/test_table_write_long_write_ctrl.sv
// Self-checking bench for the table write controller
`timescale 1ns/1ps
`include "tlw_params.svh"
module test_table_write_long_write_ctrl;
	logic        clock = 1'h0, arst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic        programPinAtVpp = 1'h0, globalHighEnable = 1'h0, peripheralLowEnable = 1'h0;
	logic [7:0]  paddr = 8'h0, irqFlag = 8'h0, irqEnable = 8'h0, irqPriority = 8'h0, memRdByte;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, memRdEn, memProgram, memConfigSpace, coreHalt, coreSleep;
	logic        resumeNext, vectorHigh, vectorLow, lastErr, progPrev = 1'h0;
	logic [21:0] memRdAddr;
	logic [20:0] memWordAddr;
	logic [15:0] memWrData;
	logic [2:0]  endCode = 3'h0;
	// Each entry: priority enable, global high, peripheral low, source priority, end pulse
	logic [6:0]  vt [4] = '{7'h22, 7'h6a, 7'h51, 7'h64};
	int          fail_count = 0, n_checks = 0, progCount = 0, c;
	tlw_table_write_ctrl tlw_table_write_ctrl_i (.clock, .arst_n, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .programPinAtVpp, .irqFlag, .irqEnable,
		.irqPriority, .globalHighEnable, .peripheralLowEnable, .memRdByte, .memRdEn,
		.memRdAddr, .memProgram, .memWordAddr, .memConfigSpace, .memWrData, .coreHalt,
		.coreSleep, .resumeNext, .vectorHigh, .vectorLow);
	tlw_mem_model tlw_mem_model_i (.clock, .memRdEn, .memRdAddr, .memProgram, .memWordAddr,
		.memWrData, .memRdByte);
	always #5 clock = ~clock;
	always @(posedge clock) begin
		progPrev <= memProgram;
		if (memProgram && !progPrev) progCount++;
		if (resumeNext || vectorHigh || vectorLow) endCode <= {resumeNext, vectorHigh, vectorLow};
	end
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'h1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'h1;
		do begin
			@(posedge clock);
			k++;
		end while (pready !== 1'h1 && k < 20);
		if (k >= 20) begin
			fail_count++;
			end_of_test();
		end
		rd = prdata;
		lastErr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clock);
	endtask
	task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		apb(a, 1'h0, 32'h0);
		check(what, exp, rd);
	endtask
	task automatic op(input logic [21:0] p, input logic [7:0] l, input logic [2:0] code);
		apb(`TLW_OFS_POINTER, 1'h1, 32'(p));
		apb(`TLW_OFS_LATCH, 1'h1, 32'(l));
		apb(`TLW_OFS_OP, 1'h1, 32'(code));
	endtask
	// Polls busy; a long write that never ends is cut off here
	task automatic idle;
		int k;
		k = 0;
		do begin
			apb(`TLW_OFS_CTRL, 1'h0, 32'h0);
			k++;
		end while (rd[`TLW_CTRL_BUSY_BIT] !== 1'h0 && k < 20);
		if (k >= 20) begin
			fail_count++;
			end_of_test();
		end
	endtask
	initial begin
		repeat (2) @(posedge clock);
		arst_n <= 1'h1;
		@(posedge clock);
		rdchk("ctrl reset", `TLW_OFS_CTRL, 32'h0);
		rdchk("latch reset", `TLW_OFS_LATCH, 32'h0);
		rdchk("pointer reset", `TLW_OFS_POINTER, 32'h0);
		apb(8'h10, 1'h0, 32'h0);
		check("unmapped err", 32'h1, 32'(lastErr));
		check("unmapped data", 32'h0, rd);
		programPinAtVpp <= 1'h1;
		op(22'h10, 8'haa, 3'h4);
		idle();
		op(22'h11, 8'hbb, 3'h4);
		idle();
		check("short only", 32'h0, 32'(progCount));
		apb(`TLW_OFS_CTRL, 1'h1, 32'h1);
		apb(`TLW_OFS_CTRL, 1'h1, 32'h0);
		rdchk("enable sticks", `TLW_OFS_CTRL, 32'h5);
		irqEnable <= 8'h01;
		op(22'h20, 8'h34, 3'h5);
		idle();
		rdchk("post inc", `TLW_OFS_POINTER, 32'h21);
		check("even no program", 32'h0, 32'(progCount));
		apb(`TLW_OFS_LATCH, 1'h1, 32'h12);
		apb(`TLW_OFS_OP, 1'h1, 32'h4);
		apb(`TLW_OFS_OP, 1'h1, 32'h4);
		check("op while busy", 32'h1, 32'(lastErr));
		check("word addr", 32'h10, 32'(memWordAddr));
		check("word data", 32'h1234, 32'(memWrData));
		check("halted", 32'h7, 32'({memProgram, coreHalt, coreSleep}));
		irqFlag <= 8'h02;
		repeat (8) @(posedge clock);
		check("still programming", 32'h1, 32'(memProgram));
		irqFlag <= 8'h03;
		idle();
		check("resume next", 32'h4, 32'(endCode));
		rdchk("ended by irq", `TLW_OFS_CTRL, 32'h35);
		rdchk("pointer kept", `TLW_OFS_POINTER, 32'h21);
		irqFlag <= 8'h00;
		op(22'h20, 8'h00, 3'h3);
		idle();
		rdchk("odd byte", `TLW_OFS_LATCH, 32'h12);
		op(22'h20, 8'h00, 3'h2);
		idle();
		rdchk("even byte", `TLW_OFS_LATCH, 32'h34);
		rdchk("post dec", `TLW_OFS_POINTER, 32'h1f);
		op(22'h3fffff, 8'h00, 3'h3);
		idle();
		rdchk("pre inc wrap", `TLW_OFS_POINTER, 32'h200000);
		// Flag already pending, so each long write ends one cycle after entry
		irqFlag <= 8'h01;
		for (int i = 0; i < 4; i++) begin
			apb(`TLW_OFS_CTRL, 1'h1, {30'h0, vt[i][6], 1'h1});
			globalHighEnable <= vt[i][5];
			peripheralLowEnable <= vt[i][4];
			irqPriority <= {7'h0, vt[i][3]};
			op(22'h41, 8'h50, 3'h4);
			idle();
			check("end pulse", 32'(vt[i][2:0]), 32'(endCode));
		end
		irqFlag <= 8'h00;
		programPinAtVpp <= 1'h0;
		repeat (3) @(posedge clock);
		c = progCount;
		op(22'h41, 8'h66, 3'h4);
		idle();
		check("no voltage", 32'(c), 32'(progCount));
		programPinAtVpp <= 1'h1;
		repeat (3) @(posedge clock);
		op(22'h200001, 8'h77, 3'h4);
		repeat (4) @(posedge clock);
		check("programming", 32'h1, 32'(memProgram));
		check("config space", 32'h1, 32'(memConfigSpace));
		check("config word", 32'h100000, 32'(memWordAddr));
		arst_n <= 1'h0;
		@(posedge clock);
		check("reset ends", 32'h0, 32'(memProgram));
		arst_n <= 1'h1;
		@(posedge clock);
		apb(`TLW_OFS_CTRL, 1'h0, 32'h0);
		check("enable cleared", 32'h0, rd & 32'h1);
		end_of_test();
	end
endmodule // test_table_write_long_write_ctrl
